/* design/reset_wake_interrupt_ctrl.sv */
// reset cause flags, sleep wake-up and interrupt steering with axi4-lite
//
// Contract
// R1 - reset comes from power-on, reset pin pulse or watchdog expiry
// R2 - pin reset while running keeps both cause flags
// R3 - pin reset waking from sleep gives watchdog flag 1, sleep flag 0
// R4 - watchdog reset while running clears watchdog flag, keeps sleep flag
// R5 - watchdog wake from sleep leaves both flags at 0
// R6 - power-on sets both flags; change wake gives 1 and 0
// R7 - watchdog clear sets both; sleep gives 1,0; time-out clears watchdog flag
// R8 - three falling-edge sources: timer overflow, port change, external pin; port change here sets on either edge
// R9 - software reads port 6 before enabling change interrupt
// R10 - change detector skips output pins and bit 0 used as external input
// R11 - enabled change wakes sleep; vector 008h only if global enable set
// R12 - pending flags held per source, mask register selects sources
// R13 - enable instruction sets global enable, disable clears it
// R14 - enabled interrupt with global enable sends next fetch to 008h
// R15 - service routine clears the flag before return and re-enable
// R16 - flags other than change flag set regardless of mask or enable
// R17 - flag register reads as stored flags and mask
// R18 - return instruction also sets the global enable
// R19 - software interrupt when enabled sends next fetch to 001h
// R20 - change flag latches only while its mask bit is set
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_wake_interrupt_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        power_on_n,
    input  wire logic        reset_pin_n,
    input  wire logic        watchdog_expire,
    input  wire logic        timer_ovf_n,
    input  wire logic [7:0]  port6_pins,
    input  wire logic [7:0]  port6_is_out,
    input  wire logic        ext_int_sel,
    input  wire logic        port6_read,
    input  wire logic        global_irq_on_instr,
    input  wire logic        global_irq_off_instr,
    input  wire logic        irq_return_instr,
    input  wire logic        sleep_instr,
    input  wire logic        watchdog_clear_instr,
    input  wire logic        soft_irq_instr,
    input  wire logic        fetch_taken,
    output logic             core_reset,
    output logic             sleeping,
    output logic             wake,
    output logic             vector_load,
    output logic [11:0]      vector_addr,
    output logic             t_flag,
    output logic             p_flag,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [2:0] {
        ST_RUN   = 3'h1,
        ST_SLEEP = 3'h2,
        ST_RESET = 3'h4
    } run_state_t;

    run_state_t  state;
    run_state_t  next_state;
    logic [1:0]  pins_s;
    logic [7:0]  p6_s;
    logic [1:0]  pins_last;
    logic [1:0]  pins_fell;
    logic [7:0]  p6_last;
    logic [7:0]  p6_fell;
    logic [7:0]  p6_ref;
    logic [2:0]  flags;
    logic [2:0]  mask;
    logic        gie;
    logic        soft_en;
    logic        power_seen;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // reset pin and timer overflow are pins, both pass the synchroniser
    rwic_sync #(.W(2)) u_sync_pins (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({reset_pin_n, timer_ovf_n}),
        .q       (pins_s)
    );
    rwic_sync #(.W(8)) u_sync_p6 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (port6_pins),
        .q       (p6_s)
    );
    rwic_fall #(.W(2)) u_fall_pins (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (pins_s),
        .last    (pins_last),
        .fell    (pins_fell)
    );
    rwic_fall #(.W(8)) u_fall_p6 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .level   (p6_s),
        .last    (p6_last),
        .fell    (p6_fell)
    );

    // reset pin held low keeps the core in reset until it returns high
    wire pin_low     = ~pins_s[1]; // R1
    wire timer_event = pins_fell[0]; // R8
    wire ext_event   = ext_int_sel & p6_fell[0]; // R8
    wire [7:0] p6_watch = ~port6_is_out & {7'h7f, ~ext_int_sel}; // R10
    wire change_raw  = |((p6_s ^ p6_ref) & p6_watch); // R8
    wire change_evt  = change_raw & mask[rwic_pkg::BIT_CHANGE]; // R20
    wire [2:0] set_bits = {ext_event, change_evt, timer_event}; // R16
    wire pending     = |(flags & mask); // R12
    wire in_sleep    = (state == ST_SLEEP);
    wire irq_take    = pending & gie & (state == ST_RUN); // R14
    wire soft_take   = soft_irq_instr & soft_en & (state == ST_RUN); // R19
    wire wake_change = in_sleep & change_evt; // R11

    // software register strobes
    wire wr_fire   = aw_held & w_held & ~s_axi_bvalid;
    wire wr_flag   = wr_fire & (aw_addr == rwic_pkg::ADDR_FLAG) & w_strb[0];
    wire wr_mask   = wr_fire & (aw_addr == rwic_pkg::ADDR_MASK) & w_strb[0];
    wire wr_ctrl   = wr_fire & (aw_addr == rwic_pkg::ADDR_CTRL) & w_strb[0];
    wire wr_hit    = (aw_addr == rwic_pkg::ADDR_FLAG) |
                     (aw_addr == rwic_pkg::ADDR_MASK) |
                     (aw_addr == rwic_pkg::ADDR_CTRL);
    wire rd_hit    = (s_axi_araddr == rwic_pkg::ADDR_FLAG) |
                     (s_axi_araddr == rwic_pkg::ADDR_MASK) |
                     (s_axi_araddr == rwic_pkg::ADDR_STATUS) |
                     (s_axi_araddr == rwic_pkg::ADDR_CTRL);
    wire [31:0] rd_val =
        (s_axi_araddr == rwic_pkg::ADDR_FLAG) ? {29'h0, flags & mask} : // R17
        (s_axi_araddr == rwic_pkg::ADDR_MASK) ? {29'h0, mask} :
        (s_axi_araddr == rwic_pkg::ADDR_STATUS) ?
            {27'h0, t_flag, p_flag, 1'b0, in_sleep, gie} :
        (s_axi_araddr == rwic_pkg::ADDR_CTRL) ? {31'h0, soft_en} : 32'h0;

    // run, sleep and held reset; watchdog reset is one cycle long
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN:   if (pin_low) next_state = ST_RESET;
                      else if (sleep_instr) next_state = ST_SLEEP;
            ST_SLEEP: if (pin_low) next_state = ST_RESET;
                      else if (wake_change) next_state = ST_RUN;
            ST_RESET: if (!pin_low) next_state = ST_RUN;
            default:  next_state = ST_RUN;
        endcase
    end

    // state and reset cause flags; aresetn stands for power-on
    always_ff @(posedge aclk) begin
        if (!aresetn || !power_on_n) begin
            state      <= ST_RUN;
            t_flag     <= 1'b1; // R6
            p_flag     <= 1'b1; // R6
            power_seen <= 1'b0;
        end else begin
            state      <= watchdog_expire ? ST_RUN : next_state; // R1
            power_seen <= 1'b1;
            if (pin_low && in_sleep) begin
                t_flag <= 1'b1; // R3
                p_flag <= 1'b0; // R3
            end else if (watchdog_expire) begin
                t_flag <= 1'b0; // R4
                if (in_sleep) p_flag <= 1'b0; // R5
            end else if (wake_change) begin
                t_flag <= 1'b1; // R6
                p_flag <= 1'b0; // R6
            end else if (watchdog_clear_instr && state == ST_RUN) begin
                t_flag <= 1'b1; // R7
                p_flag <= 1'b1; // R7
            end else if (sleep_instr && state == ST_RUN && !pin_low) begin
                t_flag <= 1'b1; // R7
                p_flag <= 1'b0; // R7
            end
            // pin reset while running leaves both flags alone  R2
        end
    end

    // pending flags, set wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn || core_reset) begin
            flags <= rwic_pkg::FLAG_RESET;
            mask  <= rwic_pkg::MASK_RESET;
            gie   <= 1'b0;
        end else begin
            flags <= (wr_flag ? w_data[2:0] & flags : flags) | set_bits; // R12
            if (wr_mask) mask <= w_data[2:0]; // R12
            if (global_irq_on_instr || irq_return_instr) gie <= 1'b1; // R13 R18
            else if (global_irq_off_instr || irq_take) gie <= 1'b0; // R13
        end
    end

    // change reference follows a port read; software must read first  R9
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p6_ref  <= 8'hff;
            soft_en <= 1'b0;
        end else begin
            if (port6_read || change_raw) p6_ref <= p6_s;
            if (wr_ctrl) soft_en <= w_data[0];
        end
    end

    // core-facing outputs; vector held until the sequencer takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_reset  <= 1'b1;
            sleeping    <= 1'b0;
            wake        <= 1'b0;
            vector_load <= 1'b0;
            vector_addr <= 12'h000;
        end else begin
            core_reset  <= ~power_on_n | watchdog_expire |
                           (next_state == ST_RESET) | ~power_seen; // R1
            sleeping    <= (next_state == ST_SLEEP) & ~watchdog_expire;
            wake        <= wake_change; // R11
            if (irq_take || (wake_change && gie)) begin
                vector_load <= 1'b1;
                vector_addr <= rwic_pkg::VEC_IRQ; // R11 R14
            end else if (soft_take) begin
                vector_load <= 1'b1;
                vector_addr <= rwic_pkg::VEC_SOFT; // R19
            end else if (fetch_taken) begin
                vector_load <= 1'b0;
            end
        end
    end

    // axi4-lite write side: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 32'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rwic_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[31:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? rwic_pkg::RESP_OKAY
                                       : rwic_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // axi4-lite read side, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= rwic_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {s_axi_araddr[1:0] == 2'b00} ? rd_val : 32'h0;
                s_axi_rresp  <= rd_hit ? rwic_pkg::RESP_OKAY
                                       : rwic_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    AST_TIMER_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_event && !core_reset |=> flags[0]) // R16
        else $error("timer flag not set");
    AST_CHANGE_MASKED: assert property (@(posedge aclk) disable iff (!aresetn)
        !mask[1] && !$past(mask[1]) && !core_reset && !$past(core_reset)
        && $past(!flags[1]) |-> !flags[1]) // R20
        else $error("change flag set while masked");
    AST_IRQ_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_take |=> vector_load && vector_addr == 12'h008) // R14
        else $error("interrupt vector wrong");
    AST_SOFT_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_take && !irq_take |=> vector_addr == 12'h001) // R19
        else $error("soft vector wrong");
    AST_GIE_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        (global_irq_on_instr || irq_return_instr) && !core_reset
        |=> gie) // R13
        else $error("global enable not set");
    AST_WDT_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
        watchdog_expire && power_on_n && !(pin_low && in_sleep)
        |=> !t_flag ##0 core_reset) // R4
        else $error("watchdog reset effect wrong");
    AST_SLEEP_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_instr && state == ST_RUN && !pin_low && !watchdog_expire
        && !watchdog_clear_instr && power_on_n |=> t_flag && !p_flag) // R7
        else $error("sleep flags wrong");
    AST_PIN_RUN_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_low && !in_sleep && !watchdog_expire && power_on_n
        && !watchdog_clear_instr && !sleep_instr
        |=> $stable(t_flag) && $stable(p_flag)) // R2
        else $error("pin reset changed flags");
    AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_change && !pin_low && !watchdog_expire && power_on_n
        |=> wake && !sleeping && t_flag && !p_flag) // R11
        else $error("change wake wrong");
endmodule : reset_wake_interrupt_ctrl

/* design/rwic_fall.sv */
// falling-edge detector on synchronised levels
`timescale 1ns/1ps
module rwic_fall #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] last,
    output logic      [W-1:0] fell
);
    // idle level is high, so a reset does not fake an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last <= '1;
        end else begin
            last <= level;
        end
    end
    assign fell = last & ~level;
endmodule : rwic_fall

/* design/rwic_pkg.sv */
// constants shared by the reset, wake and interrupt controller
package rwic_pkg;
    localparam logic [31:0] ADDR_FLAG   = 32'h0000000f * 4;
    localparam logic [31:0] ADDR_MASK   = 32'h0000001f * 4;
    localparam logic [31:0] ADDR_STATUS = 32'h00000004 * 4;
    localparam logic [31:0] ADDR_CTRL   = 32'h00000020;
    localparam int BIT_TIMER  = 0;
    localparam int BIT_CHANGE = 1;
    localparam int BIT_EXT    = 2;
    localparam int BIT_TFLAG  = 4;
    localparam int BIT_PFLAG  = 3;
    localparam int BIT_GIE    = 0;
    localparam int BIT_SLEEP  = 1;
    localparam logic [2:0]  FLAG_RESET  = 3'h0;
    localparam logic [2:0]  MASK_RESET  = 3'h0;
    localparam logic [11:0] VEC_IRQ     = 12'h008;
    localparam logic [11:0] VEC_SOFT    = 12'h001;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : rwic_pkg

/* design/rwic_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rwic_sync #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : rwic_sync

/* verif/reset_wake_interrupt_ctrl_tb.sv */
// self-checking bench for the reset, wake and interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module reset_wake_interrupt_ctrl_tb;
    logic        aclk = 0, aresetn = 0, power_on_n = 1, reset_pin_n = 1;
    logic        timer_ovf_n = 1, ext_int_sel = 0, fetch_taken;
    logic [7:0]  port6_pins = 8'hff, port6_is_out = 8'h20, ins = 8'h00;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        core_reset, sleeping, wake, vector_load, t_flag, p_flag;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [11:0] vector_addr;
    logic [2:0]  dly = 3'h0;
    logic [34:0] q[$];
    int          failures = 0, n_checks = 0, seed;
    localparam logic [31:0] FL = rwic_pkg::ADDR_FLAG;
    localparam logic [31:0] MK = rwic_pkg::ADDR_MASK;
    localparam logic [1:0]  OK = rwic_pkg::RESP_OKAY;

    always #12.5 aclk = ~aclk;

    reset_wake_interrupt_ctrl reset_wake_interrupt_ctrl_i (
        .global_irq_on_instr(ins[0]), .global_irq_off_instr(ins[1]),
        .irq_return_instr(ins[2]), .sleep_instr(ins[3]),
        .watchdog_clear_instr(ins[4]), .soft_irq_instr(ins[5]),
        .watchdog_expire(ins[6]), .port6_read(ins[7]), .*);
    rwic_core_model rwic_core_model_i (.aclk(aclk), .aresetn(aresetn),
        .vector_load(vector_load), .delay(dly), .fetch_taken(fetch_taken));

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // oldest note against each result, in arrival order
    task automatic take(input logic [34:0] got);
        logic [34:0] e;
        if (q.size() == 0) begin
            failures++;
            $display("unexpected at %0t: result with nothing pending", $time);
        end else begin
            e = q.pop_front();
            `CHK(got, e)
        end
    endtask : take

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) take({1'b0, s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) take({1'b0, s_axi_bresp, 32'h0});
        if (fetch_taken) take({3'h4, 20'h0, vector_addr});
        if (wake) take({3'h2, 32'h0});
    end

    task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
        bit ad, wd;
        q.push_back({1'b0, r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        ad = 0;
        wd = 0;
        // each channel released only at its own handshake edge
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) begin
                s_axi_awvalid <= 0;
                ad = 1;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wvalid <= 0;
                wd = 1;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 0;
        @(posedge aclk);
    endtask : axw

    task automatic axr(input logic [31:0] a, input logic [33:0] e);
        q.push_back({1'b0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask : axr

    task automatic st(input logic t, p, g);
        axr(rwic_pkg::ADDR_STATUS, {2'h0, 27'h0, t, p, 2'h0, g});
    endtask : st

    task automatic pulse(input int i);
        ins[i] <= 1'b1;
        @(posedge aclk);
        ins[i] <= 1'b0;
        @(posedge aclk);
    endtask : pulse

    task automatic pin(input int b, input logic v);
        port6_pins[b] <= v;
        repeat (8) @(posedge aclk);
    endtask : pin

    // core may hold reset a while after any cause
    task automatic settle();
        repeat (3) @(posedge aclk);
        while (core_reset !== 1'b0) @(posedge aclk);
    endtask : settle

    task automatic vec(input logic [11:0] a);
        dly <= 3'($random(seed));
        q.push_back({3'h4, 20'h0, a});
    endtask : vec

    task automatic drain();
        while (q.size() != 0) @(posedge aclk);
    endtask : drain

    task automatic nap();
        pulse(3);
        while (sleeping !== 1'b1) @(posedge aclk);
    endtask : nap

    task automatic pin_reset();
        reset_pin_n <= 0;
        repeat (4) @(posedge aclk);
        reset_pin_n <= 1;
        settle();
    endtask : pin_reset

    initial begin
        repeat (6000) @(posedge aclk);
        failures++;
        stop_test();
    end

    initial begin
        seed = 32804;
        port6_pins <= 8'($random(seed)) | 8'h09;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        settle();
        st(1, 1, 0);
        axr(32'h44, {rwic_pkg::RESP_SLVERR, 32'h0});
        axw(32'h44, 32'h1, rwic_pkg::RESP_SLVERR);
        // timer event lands with mask clear, shown only once masked in
        timer_ovf_n <= 0;
        repeat (8) @(posedge aclk);
        axr(FL, 0);
        axw(MK, 1, OK);
        axr(FL, 1);
        vec(rwic_pkg::VEC_IRQ);
        pulse(0);
        drain();
        st(1, 1, 0);
        axw(FL, 32'h6, OK);
        timer_ovf_n <= 1;
        pulse(2);
        st(1, 1, 1);
        pulse(1);
        st(1, 1, 0);
        ext_int_sel <= 1;
        pulse(7);
        axw(MK, 6, OK);
        pin(0, 0);
        pin(5, ~port6_pins[5]);
        axr(FL, 4);
        pin(3, 0);
        axr(FL, 6);
        axw(FL, 0, OK);
        axr(FL, 0);
        axw(MK, 0, OK);
        pin(3, 1);
        pin(3, 0);
        pulse(7);
        axw(MK, 7, OK);
        axr(FL, 0);
        // change wake, first with global enable off then on
        axw(MK, 0, OK);
        pin(3, 1);
        pulse(7);
        axw(MK, 2, OK);
        nap();
        q.push_back({3'h2, 32'h0});
        pin(3, 0);
        settle();
        st(1, 0, 0);
        axw(MK, 0, OK);
        axw(FL, 0, OK);
        pin(3, 1);
        pulse(7);
        axw(MK, 2, OK);
        pulse(0);
        nap();
        q.push_back({3'h2, 32'h0});
        vec(rwic_pkg::VEC_IRQ);
        pin(3, 0);
        drain();
        settle();
        st(1, 0, 0);
        axw(FL, 0, OK);
        axw(MK, 0, OK);
        axw(rwic_pkg::ADDR_CTRL, 1, OK);
        pulse(0);
        vec(rwic_pkg::VEC_SOFT);
        pulse(5);
        drain();
        // reset cause flags across every kind of reset
        pulse(4);
        st(1, 1, 1);
        pulse(6);
        settle();
        st(0, 1, 0);
        pin_reset();
        st(0, 1, 0);
        nap();
        pin_reset();
        st(1, 0, 0);
        nap();
        pulse(6);
        settle();
        st(0, 0, 0);
        power_on_n <= 0;
        repeat (3) @(posedge aclk);
        power_on_n <= 1;
        settle();
        st(1, 1, 0);
        stop_test();
    end
endmodule : reset_wake_interrupt_ctrl_tb

/* verif/rwic_core_model.sv */
// core sequencer stand-in that takes vector loads
`timescale 1ns/1ps
module rwic_core_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       vector_load,
    input  wire logic [2:0] delay,
    output logic            fetch_taken
);
    logic [2:0] wait_cnt;

    // prompt or slow answer; one-cycle pulse so each load is taken once
    always_ff @(posedge aclk) begin
        if (!aresetn || fetch_taken || !vector_load) begin
            fetch_taken <= 1'b0;
            wait_cnt    <= 3'h0;
        end else if (wait_cnt >= delay) begin
            fetch_taken <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule : rwic_core_model
